// ==== include/tdm_pkg.sv ====
// constants and types for the dual down-counting timer module
// assumes an AHB-Lite register bus and a 100 MHz hclk (the divided system clock)
package tdm_pkg;

  // =====================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_T0LO = 8'h08;
  localparam logic [7:0] ADDR_T0HI = 8'h0C;
  localparam logic [7:0] ADDR_T1LO = 8'h10;
  localparam logic [7:0] ADDR_T1HI = 8'h14;
  localparam logic [7:0] ADDR_GENERAL_CONFIG_REG_TWO = 8'h18;

  // =====================================================================
  // byte indices of the four count/reload bytes
  localparam logic [1:0] IDX_T0LO = 2'h0;
  localparam logic [1:0] IDX_T0HI = 2'h1;
  localparam logic [1:0] IDX_T1LO = 2'h2;
  localparam logic [1:0] IDX_T1HI = 2'h3;

  // =====================================================================
  // field positions
  localparam int CTL_RUN0 = 0;
  localparam int CTL_FULL0 = 1;
  localparam int CTL_RUN1 = 2;
  localparam int CTL_FULL1 = 3;
  localparam int CTL_W = 6;
  localparam int MOD_TM_LSB = 0;
  localparam int MOD_T0CS_LSB = 4;
  localparam int MOD_T1CS_LSB = 8;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_XTAL_BIT = 1;

  // =====================================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [CTL_W-1:0] RST_CTL = 6'h00;
  localparam logic [2:0] RST_FIELD = 3'h0;

  // =====================================================================
  // mode and clock select encodings
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] CS_RC_DIV1 = 3'h0;
  localparam logic [2:0] CS_RC_DIV8 = 3'h1;
  localparam logic [2:0] CS_RC_DIV32 = 3'h2;
  localparam logic [2:0] CS_RC_DIV128 = 3'h3;
  localparam logic [2:0] CS_RC_DIV512 = 3'h4;
  localparam logic [2:0] CS_LP = 3'h5;
  localparam logic [2:0] CS_T0_CASC = 3'h6;
  localparam logic [2:0] CS_T0_RC90 = 3'h7;
  localparam logic [2:0] CS_T1_PIN = 3'h6;
  localparam logic [2:0] CS_XTAL_DIV6 = 3'h0;
  localparam logic [2:0] CS_XTAL_DIV512 = 3'h1;

  // prescaler terminal counts
  localparam logic [2:0] XTAL6_LAST = 3'h5;

  // synchroniser lanes
  localparam int SY_RC12 = 0;
  localparam int SY_LP = 1;
  localparam int SY_XTAL = 2;
  localparam int SY_RC90 = 3;
  localparam int SY_PIN = 4;

  // =====================================================================
  // types
  typedef struct packed {
    logic on;
    logic w16;
    logic rl;
    logic src1;
    logic [1:0] lo;
    logic [1:0] hi;
    logic [1:0] rlo;
    logic [1:0] rhi;
  } tdm_chcfg_t;

  typedef tdm_chcfg_t [2:0] tdm_map_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
  } tdm_aph_t;

  typedef struct packed {
    logic [3:0][7:0] cnt;
    logic [CTL_W-1:0] ctl;
    logic [2:0] tm;
    logic [2:0] t0cs;
    logic [2:0] t1cs;
    logic en;
    logic xen;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [8:0] rc_pre;
    logic [8:0] x_pre512;
    logic [2:0] x_pre6;
    logic [2:0] r90_pre;
    tdm_aph_t aph;
    logic [31:0] rdata;
    logic baud;
  } tdm_state_t;

endpackage

// ==== design/tdm_timer.sv ====
// dual down-counting timer module with AHB-Lite register access
// assumes hclk is the divided system clock and the counting clocks arrive
// as asynchronous square waves far slower than hclk
`timescale 1ns/1ns

module tdm_timer
  import tdm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rc12m_clk_in,
  input wire logic lp2k2_clk_in,
  input wire logic xtal_clk_in,
  input wire logic rc90k_clk_in,
  input wire logic port_pin_two,
  output logic radio_bit_tick,
  output logic timer_power_on
);

  // =====================================================================
  // helper functions

  // channel layout per mode; byte 0..3 = t0 low, t0 high, t1 low, t1 high
  function automatic tdm_map_t tdm_mode_map(input logic [2:0] m);
    tdm_map_t r;
    r = '0;
    case (m)
      MODE_1: begin
        r[0] = '{1'b1, 1'b0, 1'b1, 1'b0, IDX_T0LO, IDX_T0HI, IDX_T0HI, IDX_T0HI};
        r[1] = '{1'b1, 1'b0, 1'b1, 1'b1, IDX_T1LO, IDX_T1HI, IDX_T1HI, IDX_T1HI};
      end
      MODE_2: begin
        r[1] = '{1'b1, 1'b1, 1'b1, 1'b1, IDX_T1LO, IDX_T1HI, IDX_T0LO, IDX_T0HI};
      end
      MODE_3: begin
        r[0] = '{1'b1, 1'b1, 1'b0, 1'b0, IDX_T0LO, IDX_T0HI, IDX_T0LO, IDX_T0HI};
        r[1] = '{1'b1, 1'b0, 1'b1, 1'b1, IDX_T1LO, IDX_T1HI, IDX_T1HI, IDX_T1HI};
      end
      MODE_4: begin
        r[0] = '{1'b1, 1'b0, 1'b0, 1'b0, IDX_T0LO, IDX_T0LO, IDX_T0LO, IDX_T0LO};
        r[1] = '{1'b1, 1'b0, 1'b1, 1'b1, IDX_T1LO, IDX_T1HI, IDX_T1HI, IDX_T1HI};
        r[2] = '{1'b1, 1'b0, 1'b0, 1'b0, IDX_T0HI, IDX_T0HI, IDX_T0HI, IDX_T0HI};
      end
      MODE_5: begin
        r[0] = '{1'b1, 1'b0, 1'b0, 1'b0, IDX_T0LO, IDX_T0LO, IDX_T0LO, IDX_T0LO};
        r[1] = '{1'b1, 1'b0, 1'b0, 1'b1, IDX_T1LO, IDX_T1LO, IDX_T1LO, IDX_T1LO};
      end
      MODE_6: begin
        r[0] = '{1'b1, 1'b1, 1'b1, 1'b0, IDX_T0LO, IDX_T0HI, IDX_T1LO, IDX_T1HI};
      end
      default: begin
        // mode 0 and the calibration mode: two 16-bit single-run timers
        r[0] = '{1'b1, 1'b1, 1'b0, 1'b0, IDX_T0LO, IDX_T0HI, IDX_T0LO, IDX_T0HI};
        r[1] = '{1'b1, 1'b1, 1'b0, 1'b1, IDX_T1LO, IDX_T1HI, IDX_T1LO, IDX_T1HI};
      end
    endcase
    return r;
  endfunction

  // fast RC prescaler taps, shared by both timers
  function automatic logic tdm_rc_tick(input logic [2:0] cs, input logic edge_in,
                                       input logic [8:0] pre);
    logic t;
    t = 1'b0;
    case (cs)
      CS_RC_DIV1: t = edge_in;
      CS_RC_DIV8: t = edge_in && (&pre[2:0]);
      CS_RC_DIV32: t = edge_in && (&pre[4:0]);
      CS_RC_DIV128: t = edge_in && (&pre[6:0]);
      CS_RC_DIV512: t = edge_in && (&pre[8:0]);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // counter of one channel at zero
  function automatic logic tdm_at_zero(input tdm_chcfg_t c, input logic [3:0][7:0] b);
    return (b[c.lo] == 8'h00) && (!c.w16 || (b[c.hi] == 8'h00));
  endfunction

  // =====================================================================
  // state and combinational next value
  tdm_state_t st_r;
  tdm_state_t st_nxt;
  tdm_map_t map;
  logic [4:0] rise;
  logic lp_tick;
  logic x6_tick;
  logic x512_tick;
  logic r90_tick;
  logic tick0;
  logic tick1;
  logic [2:0] ticks;
  logic [2:0] uf;
  logic bus_wr;
  logic take;

  assign take = hsel && htrans[1] && hready;
  assign bus_wr = st_r.aph.sel && st_r.aph.wr;

  always_comb begin
    tdm_chcfg_t c;
    logic [31:0] rd;
    c = '0;
    rd = 32'h0000_0000;
    st_nxt = st_r;
    map = tdm_mode_map(st_r.tm);

    // synchronisers: first stage feeds only the second
    st_nxt.s1 = {port_pin_two, rc90k_clk_in, xtal_clk_in, lp2k2_clk_in, rc12m_clk_in};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    rise = st_r.s2 & ~st_r.s3;
    // both edges of the 2.2 kHz clock give the 4.4 kHz rate
    lp_tick = st_r.en && (st_r.s2[SY_LP] ^ st_r.s3[SY_LP]);

    // prescalers run only while the module is powered
    x6_tick = st_r.en && rise[SY_XTAL] && (st_r.x_pre6 == XTAL6_LAST);
    x512_tick = st_r.en && rise[SY_XTAL] && (&st_r.x_pre512);
    r90_tick = st_r.en && rise[SY_RC90] && (&st_r.r90_pre);
    if (st_r.en) begin
      if (rise[SY_RC12]) begin
        st_nxt.rc_pre = st_r.rc_pre + 9'h001;
      end
      if (rise[SY_XTAL]) begin
        st_nxt.x_pre512 = st_r.x_pre512 + 9'h001;
        st_nxt.x_pre6 = x6_tick ? 3'h0 : st_r.x_pre6 + 3'h1;
      end
      if (rise[SY_RC90]) begin
        st_nxt.r90_pre = st_r.r90_pre + 3'h1;
      end
    end

    // timer 1 source
    if (st_r.xen && st_r.t1cs == CS_XTAL_DIV6) begin
      tick1 = x6_tick;
    end else if (st_r.t1cs == CS_LP) begin
      tick1 = lp_tick;
    end else if (st_r.t1cs == CS_T1_PIN) begin
      tick1 = st_r.en && rise[SY_PIN];
    end else begin
      tick1 = st_r.en && tdm_rc_tick(st_r.t1cs, rise[SY_RC12], st_r.rc_pre);
    end
    uf[1] = map[1].on && st_r.ctl[CTL_RUN1] && tick1 && tdm_at_zero(map[1], st_r.cnt);

    // timer 0 source; the cascade takes timer 1 underflow in the same cycle
    if (st_r.xen && st_r.t0cs == CS_XTAL_DIV6) begin
      tick0 = x6_tick;
    end else if (st_r.xen && st_r.t0cs == CS_XTAL_DIV512) begin
      tick0 = x512_tick;
    end else if (st_r.t0cs == CS_LP) begin
      tick0 = lp_tick;
    end else if (st_r.t0cs == CS_T0_CASC) begin
      tick0 = st_r.en && uf[1];
    end else if (st_r.t0cs == CS_T0_RC90) begin
      tick0 = r90_tick;
    end else begin
      tick0 = st_r.en && tdm_rc_tick(st_r.t0cs, rise[SY_RC12], st_r.rc_pre);
    end
    ticks = {tick0, tick1, tick0};
    uf[0] = map[0].on && st_r.ctl[CTL_RUN0] && tick0 && tdm_at_zero(map[0], st_r.cnt);
    uf[2] = map[2].on && st_r.ctl[4] && tick0 && tdm_at_zero(map[2], st_r.cnt);

    // counting; ticks are zero while disabled so nothing moves
    for (int ch = 0; ch < 3; ch++) begin
      c = map[ch];
      if (uf[ch]) begin
        if (c.rl) begin
          st_nxt.cnt[c.lo] = st_r.cnt[c.rlo];
          if (c.w16) begin
            st_nxt.cnt[c.hi] = st_r.cnt[c.rhi];
          end
        end else begin
          st_nxt.ctl[2*ch] = 1'b0;
        end
      end else if (c.on && st_r.ctl[2*ch] && ticks[ch]) begin
        st_nxt.cnt[c.lo] = st_r.cnt[c.lo] - 8'h01;
        if (c.w16 && st_r.cnt[c.lo] == 8'h00) begin
          st_nxt.cnt[c.hi] = st_r.cnt[c.hi] - 8'h01;
        end
      end
    end

    // data phase write; a software write beats the counter in that cycle
    if (bus_wr) begin
      case (st_r.aph.addr)
        ADDR_CTRL: st_nxt.ctl = hwdata[CTL_W-1:0];
        ADDR_MODE: begin
          st_nxt.tm = hwdata[MOD_TM_LSB +: 3];
          st_nxt.t0cs = hwdata[MOD_T0CS_LSB +: 3];
          st_nxt.t1cs = hwdata[MOD_T1CS_LSB +: 3];
        end
        ADDR_T0LO: st_nxt.cnt[IDX_T0LO] = hwdata[7:0];
        ADDR_T0HI: st_nxt.cnt[IDX_T0HI] = hwdata[7:0];
        ADDR_T1LO: st_nxt.cnt[IDX_T1LO] = hwdata[7:0];
        ADDR_T1HI: st_nxt.cnt[IDX_T1HI] = hwdata[7:0];
        ADDR_GENERAL_CONFIG_REG_TWO: begin
          st_nxt.en = hwdata[CFG_EN_BIT];
          st_nxt.xen = hwdata[CFG_XTAL_BIT];
        end
        default: st_nxt.en = st_r.en;
      endcase
    end
    // an underflow in the clearing cycle still sets the flag
    for (int ch = 0; ch < 3; ch++) begin
      if (uf[ch]) begin
        st_nxt.ctl[2*ch+1] = 1'b1;
      end
    end

    st_nxt.baud = uf[1] && (st_r.tm == MODE_1 || st_r.tm == MODE_2 || st_r.tm == MODE_3);

    // address phase capture and read data from the post-write value
    st_nxt.aph = '{take, hwrite, haddr[7:0]};
    if (take && !hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: rd[CTL_W-1:0] = st_nxt.ctl;
        ADDR_MODE: begin
          rd[MOD_TM_LSB +: 3] = st_nxt.tm;
          rd[MOD_T0CS_LSB +: 3] = st_nxt.t0cs;
          rd[MOD_T1CS_LSB +: 3] = st_nxt.t1cs;
        end
        ADDR_T0LO: rd[7:0] = st_nxt.cnt[IDX_T0LO];
        ADDR_T0HI: rd[7:0] = st_nxt.cnt[IDX_T0HI];
        ADDR_T1LO: rd[7:0] = st_nxt.cnt[IDX_T1LO];
        ADDR_T1HI: rd[7:0] = st_nxt.cnt[IDX_T1HI];
        ADDR_GENERAL_CONFIG_REG_TWO: begin
          rd[CFG_EN_BIT] = st_nxt.en;
          rd[CFG_XTAL_BIT] = st_nxt.xen;
        end
        default: rd = 32'h0000_0000;
      endcase
    end
    st_nxt.rdata = rd;
  end

  // =====================================================================
  // state register, clocked by the system clock only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{cnt: {4{RST_BYTE}}, ctl: RST_CTL, tm: RST_FIELD, t0cs: RST_FIELD,
                t1cs: RST_FIELD, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign radio_bit_tick = st_r.baud;
  assign timer_power_on = st_r.en;

  // =====================================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  enable_write_a: assert property (
    (bus_wr && st_r.aph.addr == ADDR_GENERAL_CONFIG_REG_TWO) |=> (st_r.en == $past(hwdata[CFG_EN_BIT])))
    else $error("module enable did not follow the config write");

  mode_write_a: assert property (
    (bus_wr && st_r.aph.addr == ADDR_MODE) |=> (st_r.tm == $past(hwdata[2:0])))
    else $error("mode field did not follow the mode write");

  single_count_a: assert property (
    (map[0].on && !map[0].rl && st_r.ctl[CTL_RUN0] && tick0 && !uf[0] && !bus_wr)
    |=> (st_r.cnt[map[0].lo] == $past(st_r.cnt[map[0].lo]) - 8'h01))
    else $error("single-run timer did not count down by one");

  single_stop_a: assert property (
    (uf[0] && !map[0].rl && !bus_wr) |=> (!st_r.ctl[CTL_RUN0] && st_r.ctl[CTL_FULL0]))
    else $error("single-run underflow did not stop the timer");

  reload_copy_a: assert property (
    (uf[1] && map[1].rl && !bus_wr)
    |=> (st_r.cnt[map[1].lo] == $past(st_r.cnt[map[1].rlo]) && st_r.ctl[CTL_RUN1]))
    else $error("reload timer did not reload on underflow");

  full_sticky_a: assert property (
    (st_r.ctl[CTL_FULL1] && !bus_wr) |=> st_r.ctl[CTL_FULL1])
    else $error("full flag dropped without a software write");

  halt_hold_a: assert property (
    (st_r.tm == MODE_1 && !st_r.ctl[CTL_RUN0] && !bus_wr) |=> $stable(st_r.cnt[IDX_T0LO]))
    else $error("stopped reload timer changed its count");

  radio_mode_a: assert property (
    radio_bit_tick |-> ($past(st_r.tm) >= MODE_1 && $past(st_r.tm) <= MODE_3 && $past(uf[1])))
    else $error("radio bit tick outside modes one to three");

  cascade_tick_a: assert property (
    (st_r.en && !st_r.xen && st_r.t0cs == CS_T0_CASC) |-> (tick0 == uf[1]))
    else $error("cascaded timer 0 missed a timer 1 underflow");

  idle_freeze_a: assert property (
    (!st_r.en && !bus_wr) |=> ($stable(st_r.cnt) && $stable(st_r.ctl)))
    else $error("disabled module changed a count or a flag");

  ctrl_write_a: assert property (
    (bus_wr && st_r.aph.addr == ADDR_CTRL && uf == 3'h0)
    |=> (st_r.ctl == $past(hwdata[CTL_W-1:0])))
    else $error("control register did not take the written value");

  byte_write_a: assert property (
    (bus_wr && st_r.aph.addr == ADDR_T1LO) |=> (st_r.cnt[IDX_T1LO] == $past(hwdata[7:0])))
    else $error("count byte did not take the written value");

  cfg_read_a: assert property (
    (take && !hwrite && haddr[7:0] == ADDR_GENERAL_CONFIG_REG_TWO)
    |=> (hrdata[CFG_EN_BIT] == st_r.en && hrdata[CFG_XTAL_BIT] == st_r.xen))
    else $error("config read did not return the enable bits");

  full_set_a: assert property (
    uf[1] |=> st_r.ctl[CTL_FULL1])
    else $error("timer 1 underflow did not set its full flag");

  radio_tick_a: assert property (
    (uf[1] && st_r.tm >= MODE_1 && st_r.tm <= MODE_3) |=> radio_bit_tick)
    else $error("timer 1 underflow gave no radio bit tick");

  borrow_high_a: assert property (
    (map[0].on && map[0].w16 && st_r.ctl[CTL_RUN0] && tick0 && !uf[0] && !bus_wr
     && st_r.cnt[map[0].lo] == 8'h00)
    |=> (st_r.cnt[map[0].hi] == $past(st_r.cnt[map[0].hi]) - 8'h01))
    else $error("16-bit timer 0 did not borrow into its high byte");

  idle_tick_a: assert property (
    !st_r.en |-> (!tick0 && !tick1))
    else $error("disabled module produced a counting tick");

  pin_tick_a: assert property (
    (st_r.en && st_r.t1cs == CS_T1_PIN && rise[SY_PIN]) |-> tick1)
    else $error("pin rising edge did not tick timer 1");

  slow_tick_a: assert property (
    (st_r.en && st_r.t0cs == CS_LP && (st_r.s2[SY_LP] != st_r.s3[SY_LP])) |-> tick0)
    else $error("low-power clock edge did not tick timer 0");

endmodule

// ==== verif/tdm_src_model.sv ====
// counting clock model for the timer module's asynchronous source inputs
// assumes the sources run free and bear no phase relation to hclk
`timescale 1ns/1ns
module tdm_src_model #(
  parameter int RC12_HALF = 42,
  parameter int LP_HALF = 1000,
  parameter int XTAL_HALF = 19,
  parameter int RC90_HALF = 500
) (
  output logic rc12m_clk_in,
  output logic lp2k2_clk_in,
  output logic xtal_clk_in,
  output logic rc90k_clk_in
);
  // =====================================================================
  // free running sources with small start offsets; lp2k2 and rc90k edges never line up with hclk, rc12m and xtal edges drift onto it
  initial begin
    rc12m_clk_in = 1'b0;
    #3;
    forever #RC12_HALF rc12m_clk_in = ~rc12m_clk_in;
  end
  initial begin
    lp2k2_clk_in = 1'b0;
    #7;
    forever #LP_HALF lp2k2_clk_in = ~lp2k2_clk_in;
  end
  initial begin
    xtal_clk_in = 1'b0;
    #2;
    forever #XTAL_HALF xtal_clk_in = ~xtal_clk_in;
  end
  initial begin
    rc90k_clk_in = 1'b0;
    #4;
    forever #RC90_HALF rc90k_clk_in = ~rc90k_clk_in;
  end
endmodule

// ==== verif/dual_down_timer_module_bench.sv ====
// self-checking bench for the dual down-counting timer module
// assumes the source model drives the counting clocks; the bench is bus master
`timescale 1ns/1ns
module dual_down_timer_module_bench
  import tdm_pkg::*;
();
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic port_pin_two = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic radio_bit_tick;
  logic timer_power_on;
  logic rc12m, lp2k2, xtal, rc90k;
  logic dph_rd = 1'b0;
  logic [31:0] rv;
  logic [31:0] keep;
  logic [31:0] lfsr = 32'h0E07D0BD;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] regs[7] = '{ADDR_CTRL, ADDR_MODE, ADDR_T0LO, ADDR_T0HI,
                          ADDR_T1LO, ADDR_T1HI, ADDR_GENERAL_CONFIG_REG_TWO};
  logic [4:0] src_tab[6] = '{5'h08, 5'h09, 5'h0D, 5'h0F, 5'h18, 5'h19};
  int fails = 0;
  int checks = 0;
  int ticks = 0;
  int base;

  always #5 hclk = ~hclk;

  tdm_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rc12m_clk_in(rc12m), .lp2k2_clk_in(lp2k2), .xtal_clk_in(xtal),
    .rc90k_clk_in(rc90k), .port_pin_two(port_pin_two),
    .radio_bit_tick(radio_bit_tick), .timer_power_on(timer_power_on));

  tdm_src_model i_src (.rc12m_clk_in(rc12m), .lp2k2_clk_in(lp2k2),
    .xtal_clk_in(xtal), .rc90k_clk_in(rc90k));

  // =====================================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one AHB-Lite single transfer; read data lands in rv
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // a zero mask only captures the value without judging it
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[b] !== 1'b1 && n < 3000) begin
      rd(ADDR_CTRL, 32'h0, 32'h0);
      n++;
    end
    chk("flag poll", 1, rv[b]);
  endtask

  task automatic pulse_pin(input int n);
    repeat (n) begin
      @(posedge hclk);
      port_pin_two <= 1'b1;
      repeat (10) @(posedge hclk);
      port_pin_two <= 1'b0;
      repeat (10) @(posedge hclk);
    end
  endtask

  // =====================================================================
  // read data watcher: oldest note against each read data phase
  always @(posedge hclk) begin
    logic [31:0] e, m;
    if (dph_rd && hreadyout === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk("hresp", 32'h0, {31'h0, hresp});
      if (m != 32'h0) begin
        checks++;
        if ((hrdata & m) !== (e & m)) begin
          fails++;
          $display("Error hrdata at %h expected %h seen %h", haddr, e & m, hrdata & m);
        end
      end
    end
    dph_rd <= hresetn && hsel && htrans[1] && hreadyout && !hwrite;
  end

  always @(posedge hclk) begin
    if (radio_bit_tick === 1'b1) begin
      ticks <= ticks + 1;
    end
  end

  initial begin
    #400000;
    fails++;
    $display("Error watchdog expected end seen hang");
    give_verdict();
  end

  // =====================================================================
  // scenarios
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(regs[i], 32'h0, 32'hFFFFFFFF);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    chk("power", 0, timer_power_on);
    wr(ADDR_GENERAL_CONFIG_REG_TWO, 32'h1);
    rd(ADDR_GENERAL_CONFIG_REG_TWO, 32'h1, 32'hFFFFFFFF);
    chk("power", 1, timer_power_on);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      wr(ADDR_T0LO + 8'(i * 4), lfsr);
      rd(ADDR_T0LO + 8'(i * 4), {24'h0, lfsr[7:0]}, 32'hFFFFFFFF);
    end
    for (int m = 0; m < 7; m++) begin
      wr(ADDR_MODE, {21'h0, 3'(m), 1'b0, 3'(m), 1'b0, 3'(m)});
      rd(ADDR_MODE, {21'h0, 3'(m), 1'b0, 3'(m), 1'b0, 3'(m)}, 32'hFFFFFFFF);
    end
    // single run 16-bit timer 0 from six of its sources: rc /1 and /8, lp, rc90, xtal /6 and /512
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_GENERAL_CONFIG_REG_TWO, {30'h0, src_tab[i][4:3]});
      wr(ADDR_MODE, {25'h0, src_tab[i][2:0], 4'h0});
      wr(ADDR_T0LO, 32'h2);
      wr(ADDR_T0HI, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      wait_flag(CTL_FULL0);
      rd(ADDR_CTRL, 32'h2, 32'h3);
      rd(ADDR_T0LO, 32'h0, 32'hFF);
      rd(ADDR_T0HI, 32'h0, 32'hFF);
      wr(ADDR_CTRL, 32'h0);
    end
    // 8-bit reload timer 0 with a start value unlike the reload
    wr(ADDR_GENERAL_CONFIG_REG_TWO, 32'h1);
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_T0LO, 32'h1);
    wr(ADDR_T0HI, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    wait_flag(CTL_FULL0);
    rd(ADDR_T0HI, 32'h4, 32'hFF);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_CTRL, 32'h2, 32'h3);
    rd(ADDR_T0LO, 32'h0, 32'h0);
    keep = rv;
    chk("reload bound", 1, 32'(keep[7:0] <= 8'h04));
    repeat (40) @(posedge hclk);
    rd(ADDR_T0LO, keep, 32'hFF);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CTRL, 32'h0, 32'h3);
    // module disabled while a timer runs
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_GENERAL_CONFIG_REG_TWO, 32'h0);
    rd(ADDR_T0LO, 32'h0, 32'h0);
    keep = rv;
    repeat (40) @(posedge hclk);
    rd(ADDR_T0LO, keep, 32'hFF);
    rd(ADDR_CTRL, 32'h1, 32'h1);
    chk("power", 0, timer_power_on);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_GENERAL_CONFIG_REG_TWO, 32'h1);
    // cascade: pin edges underflow timer 1, each one ticks 16-bit timer 0
    wr(ADDR_MODE, 32'h663);
    wr(ADDR_T1LO, 32'h0);
    wr(ADDR_T1HI, 32'h0);
    wr(ADDR_T0LO, 32'h1);
    wr(ADDR_T0HI, 32'h1);
    base = ticks;
    wr(ADDR_CTRL, 32'h5);
    pulse_pin(2);
    rd(ADDR_T0LO, 32'hFF, 32'hFF);
    rd(ADDR_T0HI, 32'h0, 32'hFF);
    chk("radio ticks", 2, ticks - base);
    wr(ADDR_CTRL, 32'h0);
    // 8-bit single run timer 1 on pin edges, no radio ticks in mode 5
    wr(ADDR_MODE, 32'h605);
    wr(ADDR_T1LO, 32'h2);
    wr(ADDR_CTRL, 32'h4);
    pulse_pin(2);
    rd(ADDR_CTRL, 32'h4, 32'hC);
    pulse_pin(1);
    rd(ADDR_CTRL, 32'h8, 32'hC);
    rd(ADDR_T1LO, 32'h0, 32'hFF);
    chk("radio ticks", 2, ticks - base);
    give_verdict();
  end
endmodule
